// >>> pkg/pot_nv_pkg.sv
// Shared constants, address map and types for the pot protection and status register bank.
package pot_nv_pkg;

  // ----------------------------------------------------------------
  // Word geometry and address map
  // ----------------------------------------------------------------
  localparam int DATA_W = 9;
  localparam int ADDR_W = 4;
  localparam int NUM_POTS = 4;
  localparam int NV_WORDS = 9;
  localparam int NV_CTRL_BITS = 5;
  localparam logic [3:0] ADDR_VWIPER0 = 4'h0;
  localparam logic [3:0] ADDR_VWIPER1 = 4'h1;
  localparam logic [3:0] ADDR_NVWIPER0 = 4'h2;
  localparam logic [3:0] ADDR_NVWIPER1 = 4'h3;
  localparam logic [3:0] ADDR_TCTRL_LO = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_VWIPER2 = 4'h6;
  localparam logic [3:0] ADDR_VWIPER3 = 4'h7;
  localparam logic [3:0] ADDR_NVWIPER2 = 4'h8;
  localparam logic [3:0] ADDR_NVWIPER3 = 4'h9;
  localparam logic [3:0] ADDR_TCTRL_HI = 4'hA;
  localparam logic [3:0] ADDR_GP_FIRST = 4'hB;
  localparam logic [3:0] ADDR_GP_LAST = 4'hF;
  localparam logic [3:0] NV_GP_BASE_INDEX = 4'h4;

  // ----------------------------------------------------------------
  // Reset and factory values
  // ----------------------------------------------------------------
  localparam logic [8:0] NV_MID_8BIT = 9'h080;
  localparam logic [8:0] NV_MID_7BIT = 9'h040;
  localparam logic [8:0] GP_FACTORY = 9'h000;
  localparam logic [8:0] TCTRL_RESET = 9'h1FF;
  localparam logic [4:0] NV_CTRL_FACTORY = 5'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int STAT_PROTECT_BIT = 0;
  localparam int STAT_RSVD_LO_BIT = 1;
  localparam int STAT_POT0_LOCK_BIT = 2;
  localparam int STAT_POT1_LOCK_BIT = 3;
  localparam int STAT_NVWA_BIT = 4;
  localparam int STAT_POT2_LOCK_BIT = 5;
  localparam int STAT_POT3_LOCK_BIT = 6;
  localparam int STAT_RSVD_HI_BIT = 7;
  localparam int TCTRL_RSVD_BIT = 8;
  localparam int TCTRL_HW_UPPER_BIT = 7;
  localparam int TCTRL_HW_LOWER_BIT = 3;
  localparam int CTRL_WP_BIT = 0;
  localparam int CTRL_LOCK_BASE = 1;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int NV_WRITE_TIME_NS = 5000;
  localparam int NV_WRITE_CYCLES = (NV_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    OP_WRITE = 2'b00,
    OP_INC = 2'b01,
    OP_DEC = 2'b10,
    OP_READ = 2'b11
  } cmd_op_t;

  localparam logic [2:0] HV_SEL_WP = 3'h0;
  localparam logic [2:0] HV_SEL_LOCK_LAST = 3'h4;

  function automatic logic [8:0] wiper_mid(input int bits);
    wiper_mid = (bits == 7) ? NV_MID_7BIT : NV_MID_8BIT;
  endfunction : wiper_mid

endpackage : pot_nv_pkg

// >>> rtl/pot_pin_sync.sv
// Three-stage input synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/100ps
module pot_pin_sync #(
  parameter int WIDTH = 4,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1_reg <= RESET_VAL;
      stage2_reg <= RESET_VAL;
      stage3_reg <= RESET_VAL;
      pin_out <= RESET_VAL;
    end
    else
    begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      // A bit moves only where the two later stages agree.
      pin_out <= (stage2_reg & stage3_reg) | (pin_out & (stage2_reg ^ stage3_reg));
    end
  end

endmodule : pot_pin_sync

// >>> rtl/pot_nv_store.sv
// Nonvolatile word and control-bit store with a timed programming cycle.
`timescale 1ns/100ps
module pot_nv_store
  import pot_nv_pkg::*;
#(
  parameter int WIPER_BITS = 8,
  parameter int WRITE_CYCLES = NV_WRITE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic word_wr_req,
  input wire logic [3:0] word_wr_index,
  input wire logic [8:0] word_wr_data,
  input wire logic bit_wr_req,
  input wire logic [2:0] bit_wr_sel,
  input wire logic bit_wr_val,
  output logic busy,
  output logic [NV_WORDS*9-1:0] word_rdata,
  output logic [4:0] ctrl_bits
);

  localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(WRITE_CYCLES - 1);

  typedef enum logic [0:0]
  {
    ST_IDLE = 1'b0,
    ST_PROG = 1'b1
  } prog_state_t;

  prog_state_t state_reg;
  logic [CNT_W-1:0] count_reg;
  logic pend_is_bit_reg;
  logic [3:0] pend_index_reg;
  logic [8:0] pend_data_reg;
  logic [2:0] pend_sel_reg;
  logic commit;
  logic [8:0] word_reg [NV_WORDS];

  assign commit = (state_reg == ST_PROG) && (count_reg == CNT_LAST);
  assign busy = (state_reg == ST_PROG);

  // ----------------------------------------------------------------
  // Programming cycle
  // ----------------------------------------------------------------
  // The cycle runs on power alone, so the reset pin cannot cut it short.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg <= ST_IDLE;
      count_reg <= '0;
      pend_is_bit_reg <= 1'b0;
      pend_index_reg <= 4'h0;
      pend_data_reg <= 9'h000;
      pend_sel_reg <= 3'h0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          count_reg <= '0;
          if (word_wr_req || bit_wr_req)
          begin
            state_reg <= ST_PROG;
            pend_is_bit_reg <= bit_wr_req;
            pend_index_reg <= word_wr_index;
            pend_data_reg <= bit_wr_req ? {8'h00, bit_wr_val} : word_wr_data;
            pend_sel_reg <= bit_wr_sel;
          end
        end
        ST_PROG:
        begin
          count_reg <= count_reg + CNT_W'(1);
          if (commit)
          begin
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Storage, factory-initialised
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NV_WORDS; i++)
  begin : g_word
    localparam logic [8:0] FACTORY = (i < NUM_POTS) ? wiper_mid(WIPER_BITS) : GP_FACTORY;
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        word_reg[i] <= FACTORY;
      end
      else if (commit && !pend_is_bit_reg && (pend_index_reg == 4'(i)))
      begin
        word_reg[i] <= pend_data_reg;
      end
    end
    assign word_rdata[i*9 +: 9] = word_reg[i];
  end

  for (genvar b = 0; b < NV_CTRL_BITS; b++)
  begin : g_ctrl
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        ctrl_bits[b] <= NV_CTRL_FACTORY[b];
      end
      else if (commit && pend_is_bit_reg && (pend_sel_reg == 3'(b)))
      begin
        ctrl_bits[b] <= pend_data_reg[0];
      end
    end
  end

endmodule : pot_nv_store

// >>> rtl/pot_nv_protect_status_regs.sv
// Register bank with nonvolatile protection, wiper locks, status word and terminal control.
// Function
// - Nonvolatile wipers ship at mid-scale code
// - General-purpose words ship as zero
// - Five hidden nonvolatile protect and lock bits
// - Protection refuses every nonvolatile write except to the protect bit itself
// - Protect bit changes only by high-voltage command
// - Nonvolatile write needs pin and bit disabled
// - Protection never blocks volatile locations
// - Status bit 0 is pin OR bit
// - Status word at 05h, read only
// - Status bits 8, 7, 1 read one
// - Write-active flag; only volatile access meanwhile
// - Pot 3 and 2 locks block writes
// - Pot 1 and 0 locks block writes
// - Lock status reloads from nonvolatile bit
// - Two terminal words, four bits per pot
// - Terminal value applies when command completes
// - Power-on loads terminal words with 1FFh
// - One connects terminal; bit 8 reads one
// - Clear configuration bit forces pot shutdown
// - Disallowed command raises error condition
// - Reset pin restores defaults; programming completes
`timescale 1ns/100ps
module pot_nv_protect_status_regs
  import pot_nv_pkg::*;
#(
  parameter int WIPER_BITS = 8,
  parameter int WRITE_CYCLES = NV_WRITE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire pot_nv_pkg::cmd_op_t cmd_op,
  input wire logic [pot_nv_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [pot_nv_pkg::DATA_W-1:0] cmd_data,
  output logic rd_valid,
  output logic [pot_nv_pkg::DATA_W-1:0] rd_data,
  output logic cmd_refused,
  output logic cmd_error,
  input wire logic hv_cmd_valid,
  input wire logic [2:0] hv_cmd_sel,
  input wire logic hv_cmd_set,
  input wire logic write_protect_n,
  input wire logic reset_pin_n,
  input wire logic high_voltage_cmd_pin,
  input wire logic power_brownout_reset,
  output logic [pot_nv_pkg::NUM_POTS*pot_nv_pkg::DATA_W-1:0] wiper_value,
  output logic [pot_nv_pkg::DATA_W-1:0] terminal_ctrl_lo,
  output logic [pot_nv_pkg::DATA_W-1:0] terminal_ctrl_hi,
  output logic [pot_nv_pkg::NUM_POTS-1:0] pot_shutdown_force,
  output logic [pot_nv_pkg::DATA_W-1:0] lock_and_protect_status
);

  import pot_nv_pkg::*;

  localparam logic [8:0] WIPER_FULL = 9'(1 << WIPER_BITS);
  localparam logic [8:0] WIPER_RESET = wiper_mid(WIPER_BITS);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  logic wp_pin_n_s;
  logic rst_pin_n_s;
  logic hv_pin_s;
  logic por_s;

  pot_pin_sync #(
    .WIDTH(4),
    .RESET_VAL(4'h3)
  ) u_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin_in({power_brownout_reset, high_voltage_cmd_pin, reset_pin_n, write_protect_n}),
    .pin_out(pins_s)
  );

  assign wp_pin_n_s = pins_s[0];
  assign rst_pin_n_s = pins_s[1];
  assign hv_pin_s = pins_s[2];
  assign por_s = pins_s[3];

  // ----------------------------------------------------------------
  // Nonvolatile store
  // ----------------------------------------------------------------
  logic nv_busy;
  logic [NV_WORDS*9-1:0] nv_words;
  logic [4:0] nv_ctrl;
  logic nv_word_req;
  logic [3:0] nv_word_index;
  logic nv_bit_req;

  pot_nv_store #(
    .WIPER_BITS(WIPER_BITS),
    .WRITE_CYCLES(WRITE_CYCLES)
  ) u_store (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .word_wr_req(nv_word_req),
    .word_wr_index(nv_word_index),
    .word_wr_data(cmd_data),
    .bit_wr_req(nv_bit_req),
    .bit_wr_sel(hv_cmd_sel),
    .bit_wr_val(hv_cmd_set),
    .busy(nv_busy),
    .word_rdata(nv_words),
    .ctrl_bits(nv_ctrl)
  );

  // ----------------------------------------------------------------
  // Address decode and command checks
  // ----------------------------------------------------------------
  logic hold_reset;
  logic protect;
  logic [3:0] lock_reg;
  logic error_reg;
  logic is_vwiper;
  logic is_nvwiper;
  logic is_tctrl;
  logic is_status;
  logic is_gp;
  logic [1:0] pot;
  logic accept;
  logic disallowed;
  logic is_nv;
  logic do_write;
  logic blocked;

  // Either reset source is held as a level; the volatile state sits at its defaults throughout.
  assign hold_reset = por_s || !rst_pin_n_s;
  assign protect = !wp_pin_n_s || nv_ctrl[CTRL_WP_BIT];

  always_comb
  begin
    is_vwiper = 1'b0;
    is_nvwiper = 1'b0;
    is_tctrl = 1'b0;
    is_status = 1'b0;
    is_gp = 1'b0;
    pot = 2'd0;
    nv_word_index = 4'h0;
    unique case (cmd_addr)
      ADDR_VWIPER0, ADDR_VWIPER1, ADDR_VWIPER2, ADDR_VWIPER3:
      begin
        is_vwiper = 1'b1;
        pot = {cmd_addr[2], cmd_addr[0]};
      end
      ADDR_NVWIPER0, ADDR_NVWIPER1, ADDR_NVWIPER2, ADDR_NVWIPER3:
      begin
        is_nvwiper = 1'b1;
        pot = {cmd_addr[3], cmd_addr[0]};
        nv_word_index = {2'b00, pot};
      end
      ADDR_TCTRL_LO, ADDR_TCTRL_HI:
      begin
        is_tctrl = 1'b1;
      end
      ADDR_STATUS:
      begin
        is_status = 1'b1;
      end
      default:
      begin
        is_gp = 1'b1;
        nv_word_index = NV_GP_BASE_INDEX + (cmd_addr - ADDR_GP_FIRST);
      end
    endcase
  end

  assign is_nv = is_nvwiper || is_gp;
  assign accept = cmd_valid && !hold_reset && !error_reg;
  assign do_write = accept && !disallowed && (cmd_op == OP_WRITE);

  always_comb
  begin
    disallowed = 1'b0;
    if (is_status && (cmd_op != OP_READ))
    begin
      disallowed = 1'b1;
    end
    if ((is_nv || is_tctrl) && ((cmd_op == OP_INC) || (cmd_op == OP_DEC)))
    begin
      disallowed = 1'b1;
    end
    if (is_nv && nv_busy)
    begin
      disallowed = 1'b1;
    end
  end

  // Nonvolatile write starts only with both protections off and the pot unlocked.
  assign nv_word_req = do_write && is_nv && !protect && !(is_nvwiper && lock_reg[pot]);

  // Lock programming is refused while protected; the protect bit itself changes only here.
  assign nv_bit_req = hv_cmd_valid && !hold_reset && !error_reg && !nv_busy && (hv_cmd_sel <= HV_SEL_LOCK_LAST)
                      && !nv_word_req && ((hv_cmd_sel == HV_SEL_WP) || !protect);

  assign blocked = (do_write && is_nv && !nv_word_req)
                   || (accept && !disallowed && is_vwiper && (cmd_op != OP_READ) && lock_reg[pot]);

  // ----------------------------------------------------------------
  // Terminal control next values
  // ----------------------------------------------------------------
  logic [8:0] tctrl_lo_reg;
  logic [8:0] tctrl_hi_reg;
  logic [8:0] tctrl_lo_next;
  logic [8:0] tctrl_hi_next;

  always_comb
  begin
    tctrl_lo_next = tctrl_lo_reg;
    tctrl_hi_next = tctrl_hi_reg;
    if (hold_reset)
    begin
      tctrl_lo_next = TCTRL_RESET;
      tctrl_hi_next = TCTRL_RESET;
    end
    else if (do_write && is_tctrl)
    begin
      if (cmd_addr == ADDR_TCTRL_LO)
      begin
        tctrl_lo_next[3:0] = lock_reg[0] ? tctrl_lo_reg[3:0] : cmd_data[3:0];
        tctrl_lo_next[7:4] = lock_reg[1] ? tctrl_lo_reg[7:4] : cmd_data[7:4];
      end
      else
      begin
        tctrl_hi_next[3:0] = lock_reg[2] ? tctrl_hi_reg[3:0] : cmd_data[3:0];
        tctrl_hi_next[7:4] = lock_reg[3] ? tctrl_hi_reg[7:4] : cmd_data[7:4];
      end
    end
    tctrl_lo_next[TCTRL_RSVD_BIT] = 1'b1;
    tctrl_hi_next[TCTRL_RSVD_BIT] = 1'b1;
  end

  // A command is presented only once its serial transfer has finished, so outputs move then.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tctrl_lo_reg <= TCTRL_RESET;
      tctrl_hi_reg <= TCTRL_RESET;
      pot_shutdown_force <= 4'h0;
    end
    else
    begin
      tctrl_lo_reg <= tctrl_lo_next;
      tctrl_hi_reg <= tctrl_hi_next;
      pot_shutdown_force <= {~tctrl_hi_next[TCTRL_HW_UPPER_BIT], ~tctrl_hi_next[TCTRL_HW_LOWER_BIT],
                             ~tctrl_lo_next[TCTRL_HW_UPPER_BIT], ~tctrl_lo_next[TCTRL_HW_LOWER_BIT]};
    end
  end

  assign terminal_ctrl_lo = tctrl_lo_reg;
  assign terminal_ctrl_hi = tctrl_hi_reg;

  // ----------------------------------------------------------------
  // Volatile wipers
  // ----------------------------------------------------------------
  logic [8:0] wiper_reg [NUM_POTS];

  for (genvar p = 0; p < NUM_POTS; p++)
  begin : g_wiper
    always_ff @(posedge ref_clk or negedge resetn)
    begin
      if (!resetn)
      begin
        wiper_reg[p] <= WIPER_RESET;
      end
      else if (hold_reset)
      begin
        wiper_reg[p] <= nv_words[p*9 +: 9];
      end
      else if (accept && is_vwiper && (pot == 2'(p)) && !lock_reg[p])
      begin
        unique case (cmd_op)
          OP_WRITE:
          begin
            wiper_reg[p] <= (cmd_data > WIPER_FULL) ? WIPER_FULL : cmd_data;
          end
          OP_INC:
          begin
            if (wiper_reg[p] < WIPER_FULL)
            begin
              wiper_reg[p] <= wiper_reg[p] + 9'h001;
            end
          end
          OP_DEC:
          begin
            if (wiper_reg[p] != 9'h000)
            begin
              wiper_reg[p] <= wiper_reg[p] - 9'h001;
            end
          end
          OP_READ:
          begin
            wiper_reg[p] <= wiper_reg[p];
          end
        endcase
      end
    end
    assign wiper_value[p*9 +: 9] = wiper_reg[p];
  end

  // ----------------------------------------------------------------
  // Lock status and error condition
  // ----------------------------------------------------------------
  logic busy_d_reg;
  logic hv_seen_high_reg;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy_d_reg <= 1'b0;
      lock_reg <= NV_CTRL_FACTORY[4:1];
    end
    else
    begin
      busy_d_reg <= nv_busy;
      // Reloaded on reset events and after each completed programming cycle.
      if (hold_reset || (busy_d_reg && !nv_busy))
      begin
        lock_reg <= nv_ctrl[CTRL_LOCK_BASE +: NUM_POTS];
      end
    end
  end

  // The error is left by raising the high-voltage pin and then dropping it again.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      error_reg <= 1'b0;
      hv_seen_high_reg <= 1'b0;
    end
    else
    begin
      hv_seen_high_reg <= error_reg && hv_pin_s;
      if (accept && disallowed)
      begin
        error_reg <= 1'b1;
      end
      else if (hold_reset || (hv_seen_high_reg && !hv_pin_s))
      begin
        error_reg <= 1'b0;
      end
    end
  end

  assign cmd_error = error_reg;

  // ----------------------------------------------------------------
  // Status word and read path
  // ----------------------------------------------------------------
  logic [8:0] status_word;

  always_comb
  begin
    status_word = 9'h000;
    status_word[STAT_RSVD_HI_BIT +: 2] = 2'b11;
    status_word[STAT_RSVD_LO_BIT] = 1'b1;
    status_word[STAT_PROTECT_BIT] = protect;
    status_word[STAT_POT0_LOCK_BIT] = lock_reg[0];
    status_word[STAT_POT1_LOCK_BIT] = lock_reg[1];
    status_word[STAT_POT2_LOCK_BIT] = lock_reg[2];
    status_word[STAT_POT3_LOCK_BIT] = lock_reg[3];
    status_word[STAT_NVWA_BIT] = nv_busy;
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_valid <= 1'b0;
      rd_data <= 9'h000;
      cmd_refused <= 1'b0;
      lock_and_protect_status <= 9'h182;
    end
    else
    begin
      rd_valid <= accept && !disallowed && (cmd_op == OP_READ);
      cmd_refused <= blocked;
      lock_and_protect_status <= status_word;
      if (accept && !disallowed && (cmd_op == OP_READ))
      begin
        if (is_vwiper)
        begin
          rd_data <= wiper_reg[pot];
        end
        else if (is_nv)
        begin
          rd_data <= nv_words[nv_word_index*9 +: 9];
        end
        else if (is_tctrl)
        begin
          rd_data <= (cmd_addr == ADDR_TCTRL_LO) ? tctrl_lo_reg : tctrl_hi_reg;
        end
        else
        begin
          rd_data <= status_word;
        end
      end
    end
  end

endmodule : pot_nv_protect_status_regs

// >>> verification/pot_regs_assertions.sv
// Port-level assertions for the pot protection and status register bank.
`timescale 1ns/100ps
module pot_regs_assertions
  import pot_nv_pkg::*;
#(
  parameter int WRITE_CYCLES = 8
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cmd_valid,
  input wire pot_nv_pkg::cmd_op_t cmd_op,
  input wire logic [3:0] cmd_addr,
  input wire logic cmd_refused,
  input wire logic cmd_error,
  input wire logic write_protect_n,
  input wire logic reset_pin_n,
  input wire logic power_brownout_reset,
  input wire logic [8:0] terminal_ctrl_lo,
  input wire logic [8:0] terminal_ctrl_hi,
  input wire logic [3:0] pot_shutdown_force,
  input wire logic [8:0] lock_and_protect_status
);
  // ------
  // Helpers
  // ------
  // Reset pins pass a synchroniser, so a command only counts once they have been quiet a while.
  logic [2:0] quiet_reg;
  logic [9:0] busy_cnt_reg;
  logic [8:0] st;
  logic take;
  assign st = lock_and_protect_status;
  assign take = cmd_valid && !cmd_error && quiet_reg == 3'h7;
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn || !reset_pin_n || power_brownout_reset)
      quiet_reg <= 3'h0;
    else if (quiet_reg != 3'h7)
      quiet_reg <= quiet_reg + 3'h1;
  end
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn || !st[4])
      busy_cnt_reg <= 10'h000;
    else
      busy_cnt_reg <= busy_cnt_reg + 10'h001;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);
  // ------
  // Properties
  // ------
  status_rsvd_a: assert property (st[8:7] == 2'h3 && st[1])
    else $error("reserved status bits");
  term_rsvd_a: assert property (terminal_ctrl_lo[8] && terminal_ctrl_hi[8])
    else $error("terminal bit 8");
  shutdown_a: assert property (pot_shutdown_force ==
    ~{terminal_ctrl_hi[7], terminal_ctrl_hi[3], terminal_ctrl_lo[7], terminal_ctrl_lo[3]})
    else $error("shutdown force");
  protect_pin_a: assert property (!write_protect_n [*6] ##0 quiet_reg == 3'h7 |-> st[0])
    else $error("protect flag");
  status_ro_a: assert property (take && cmd_op != OP_READ && cmd_addr == ADDR_STATUS |=> cmd_error)
    else $error("status write");
  nv_refused_a: assert property (take && cmd_op == OP_WRITE && cmd_addr == ADDR_NVWIPER0 && st[0] && !st[4]
    |=> cmd_refused)
    else $error("protected write");
  lock_nibble_a: assert property (take && cmd_op == OP_WRITE && cmd_addr == ADDR_TCTRL_LO && st[2]
    |=> $stable(terminal_ctrl_lo[3:0]))
    else $error("locked nibble");
  wa_len_a: assert property ($fell(st[4]) |-> busy_cnt_reg == 10'(WRITE_CYCLES))
    else $error("write active length");
endmodule : pot_regs_assertions

bind pot_nv_protect_status_regs pot_regs_assertions #(.WRITE_CYCLES(WRITE_CYCLES)) i_pot_regs_assertions (.ref_clk,
  .resetn, .cmd_valid, .cmd_op, .cmd_addr, .cmd_refused, .cmd_error, .write_protect_n, .reset_pin_n,
  .power_brownout_reset, .terminal_ctrl_lo, .terminal_ctrl_hi, .pot_shutdown_force, .lock_and_protect_status);

// >>> verification/pot_host.sv
// Host controller model issuing serial and high-voltage commands.
`timescale 1ns/100ps
module pot_host
  import pot_nv_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rd_valid,
  input wire logic [8:0] rd_data,
  output pot_nv_pkg::cmd_op_t cmd_op,
  output logic cmd_valid,
  output logic [3:0] cmd_addr,
  output logic [8:0] cmd_data,
  output logic hv_cmd_valid,
  output logic [2:0] hv_cmd_sel,
  output logic hv_cmd_set
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_op = OP_READ;
    cmd_addr = 4'h0;
    cmd_data = 9'h000;
    hv_cmd_valid = 1'b0;
    hv_cmd_sel = 3'h7;
    hv_cmd_set = 1'b0;
  end
  // Data and address are inverted once the strobe drops, so nothing may lean on a stale value.
  task automatic send(input cmd_op_t op, input logic [3:0] a, input logic [8:0] d, output logic [8:0] q);
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = a;
    cmd_data = d;
    @(posedge ref_clk);
    #1;
    cmd_valid = 1'b0;
    cmd_data = ~d;
    cmd_addr = ~a;
    q = (rd_valid === 1'b1) ? rd_data : 'x;
  endtask : send
  task automatic hv(input logic [2:0] sel, input logic val);
    @(posedge ref_clk);
    #1;
    hv_cmd_valid = 1'b1;
    hv_cmd_sel = sel;
    hv_cmd_set = val;
    @(posedge ref_clk);
    #1;
    hv_cmd_valid = 1'b0;
    hv_cmd_sel = 3'h7;
  endtask : hv
endmodule : pot_host

// >>> verification/pot_nv_protect_status_regs_tb.sv
// Self-checking bench for the pot protection and status register bank.
`timescale 1ns/100ps
module pot_nv_protect_status_regs_tb;
  import pot_nv_pkg::*;
  logic ref_clk, resetn, write_protect_n, reset_pin_n, high_voltage_cmd_pin, power_brownout_reset;
  logic cmd_valid, rd_valid, cmd_refused, cmd_error, hv_cmd_valid, hv_cmd_set;
  cmd_op_t cmd_op;
  logic [3:0] cmd_addr, pot_shutdown_force;
  logic [2:0] hv_cmd_sel;
  logic [8:0] cmd_data, rd_data, terminal_ctrl_lo, terminal_ctrl_hi, lock_and_protect_status, q;
  logic [35:0] wiper_value;
  logic [3:0] nv_addr [9] = '{4'h2, 4'h3, 4'h8, 4'h9, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
  cmd_op_t bad_op [4] = '{OP_WRITE, OP_INC, OP_DEC, OP_INC};
  logic [3:0] bad_addr [4] = '{4'h5, 4'h5, 4'h2, 4'h4};
  int n_fail = 0, tests_run = 0, cycles = 0;
  pot_nv_protect_status_regs #(.WRITE_CYCLES(8)) i_pot_nv_protect_status_regs (.ref_clk, .resetn, .cmd_valid,
    .cmd_op, .cmd_addr, .cmd_data, .rd_valid, .rd_data, .cmd_refused, .cmd_error, .hv_cmd_valid, .hv_cmd_sel,
    .hv_cmd_set, .write_protect_n, .reset_pin_n, .high_voltage_cmd_pin, .power_brownout_reset, .wiper_value,
    .terminal_ctrl_lo, .terminal_ctrl_hi, .pot_shutdown_force, .lock_and_protect_status);
  pot_host i_pot_host (.ref_clk, .rd_valid, .rd_data, .cmd_op, .cmd_valid, .cmd_addr, .cmd_data, .hv_cmd_valid,
    .hv_cmd_sel, .hv_cmd_set);
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wt
  task automatic op(input cmd_op_t o, input logic [3:0] a, input logic [8:0] d);
    i_pot_host.send(o, a, d, q);
  endtask : op
  task automatic rdc(input logic [3:0] a, input logic [8:0] e);
    i_pot_host.send(OP_READ, a, 9'h000, q);
    chk(q, e);
  endtask : rdc
  // Outside a reset, the error leaves only on a full high then low swing of the pin.
  task automatic clr();
    high_voltage_cmd_pin = 1'b1;
    wt(6);
    high_voltage_cmd_pin = 1'b0;
    wt(6);
  endtask : clr
  initial
  begin
    resetn = 1'b0;
    write_protect_n = 1'b1;
    reset_pin_n = 1'b1;
    high_voltage_cmd_pin = 1'b0;
    power_brownout_reset = 1'b0;
    wt(4);
    resetn = 1'b1;
    wt(8);
    foreach (nv_addr[i]) rdc(nv_addr[i], (i < 4) ? 9'h080 : 9'h000);
    rdc(ADDR_STATUS, 9'h182);
    rdc(ADDR_TCTRL_HI, 9'h1FF);
    op(OP_WRITE, 4'hB, 9'h123);
    rdc(ADDR_STATUS, 9'h192);
    op(OP_WRITE, ADDR_VWIPER1, 9'h011);
    op(OP_DEC, ADDR_VWIPER1, 9'h000);
    op(OP_READ, 4'hC, 9'h000);
    chk({8'h00, cmd_error}, 9'h001);
    clr();
    chk({8'h00, cmd_error}, 9'h000);
    rdc(ADDR_VWIPER1, 9'h010);
    rdc(4'hB, 9'h123);
    write_protect_n = 1'b0;
    wt(6);
    rdc(ADDR_STATUS, 9'h183);
    op(OP_WRITE, ADDR_NVWIPER0, 9'h055);
    chk({8'h00, cmd_refused}, 9'h001);
    rdc(ADDR_NVWIPER0, 9'h080);
    op(OP_WRITE, ADDR_VWIPER0, 9'h033);
    op(OP_INC, ADDR_VWIPER0, 9'h000);
    rdc(ADDR_VWIPER0, 9'h034);
    op(OP_WRITE, ADDR_TCTRL_LO, 9'h0A5);
    rdc(ADDR_TCTRL_LO, 9'h1A5);
    chk({5'h00, pot_shutdown_force}, 9'h001);
    write_protect_n = 1'b1;
    i_pot_host.hv(HV_SEL_WP, 1'b1);
    wt(12);
    rdc(ADDR_STATUS, 9'h183);
    op(OP_WRITE, 4'hC, 9'h001);
    chk({8'h00, cmd_refused}, 9'h001);
    i_pot_host.hv(HV_SEL_WP, 1'b0);
    wt(12);
    i_pot_host.hv(3'h1, 1'b1);
    wt(12);
    i_pot_host.hv(HV_SEL_LOCK_LAST, 1'b1);
    wt(12);
    rdc(ADDR_STATUS, 9'h1C6);
    op(OP_WRITE, ADDR_VWIPER0, 9'h011);
    chk({8'h00, cmd_refused}, 9'h001);
    chk(wiper_value[8:0], 9'h034);
    op(OP_WRITE, ADDR_TCTRL_LO, 9'h000);
    rdc(ADDR_TCTRL_LO, 9'h105);
    op(OP_WRITE, ADDR_TCTRL_HI, 9'h000);
    rdc(ADDR_TCTRL_HI, 9'h1F0);
    op(OP_WRITE, ADDR_NVWIPER3, 9'h011);
    chk({8'h00, cmd_refused}, 9'h001);
    foreach (bad_op[i])
    begin
      op(bad_op[i], bad_addr[i], 9'h000);
      chk({8'h00, cmd_error}, 9'h001);
      clr();
    end
    for (int i = 0; i < 2; i++)
    begin
      op(OP_WRITE, ADDR_VWIPER2, 9'h000);
      {reset_pin_n, power_brownout_reset} = (i == 0) ? 2'b00 : 2'b11;
      wt(6);
      {reset_pin_n, power_brownout_reset} = 2'b10;
      wt(8);
      rdc(ADDR_TCTRL_LO, 9'h1FF);
      rdc(ADDR_VWIPER2, 9'h080);
      rdc(ADDR_STATUS, 9'h1C6);
      op(OP_WRITE, ADDR_TCTRL_LO, 9'h0FF);
    end
    finish_test();
  end
endmodule : pot_nv_protect_status_regs_tb
